// *** shared/crsu_defines.vh ***
// register reset values, flag positions and stack constants of the cpu register unit
`ifndef CRSU_DEFINES_VH
`define CRSU_DEFINES_VH
// condition flag bit positions
`define CRSU_BIT_CARRY 0
`define CRSU_BIT_ZERO 1
`define CRSU_BIT_NEG 2
`define CRSU_BIT_PRIO_LO 3
`define CRSU_BIT_HALF 4
`define CRSU_BIT_PRIO_HI 5
// reset values (undefined flag bits 7 and 6 are reset to one)
`define CRSU_FLAGS_RST 8'hE8
`define CRSU_SP_RST 16'h01FF
`define CRSU_SP_HIGH 8'h01
`define CRSU_SP_LOW_RST 8'hFF
`define CRSU_PRIO_DISABLE 2'h3
// register select codes for the load/store port
`define CRSU_SEL_ACC 3'h0
`define CRSU_SEL_IDX1 3'h1
`define CRSU_SEL_IDX2 3'h2
`define CRSU_SEL_SPLO 3'h3
`define CRSU_SEL_FLAGS 3'h4
`define CRSU_SEL_PCLO 3'h5
`define CRSU_SEL_PCHI 3'h6
// stack operation codes
`define CRSU_STK_NONE 3'h0
`define CRSU_STK_PUSH 3'h1
`define CRSU_STK_POP 3'h2
`define CRSU_STK_IRQ 3'h3
`define CRSU_STK_INTERRUPT_RETURN_INSTR 3'h4
`define CRSU_STK_CALL 3'h5
`define CRSU_STK_RET 3'h6
`define CRSU_STK_RSP 3'h7
// context sizes in stack bytes
`define CRSU_CTX_IRQ 3'h5
`define CRSU_CTX_CALL 3'h2
`endif

// *** logic/crsu_byte_reg.v ***
// one 8-bit architectural register with a write strobe
`timescale 1ns/1ps
module crsu_byte_reg #(
  parameter [7:0] RST_VAL = 8'h00
) (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // write port
  input wire wr_en_i,
  input wire [7:0] wr_data_i,
  // contents
  output wire [7:0] value_o
);
  reg [7:0] value_ff;
  // -----------------------------
  // storage
  // -----------------------------
  // plain load, reset to a constant so a sim never starts with x
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      value_ff <= RST_VAL;
    end else if (wr_en_i) begin
      value_ff <= wr_data_i;
    end
  end
  assign value_o = value_ff;
endmodule // crsu_byte_reg

// *** logic/crsu_flag_calc.v ***
// computes next condition flags from an alu result and flag-update controls
`timescale 1ns/1ps
`include "crsu_defines.vh"
module crsu_flag_calc (
  // current flags
  input wire [7:0] flags_i,
  // alu result side
  input wire alu_upd_i,
  input wire [7:0] alu_result_i,
  input wire alu_carry_upd_i,
  input wire alu_carry_i,
  input wire alu_half_upd_i,
  input wire alu_half_i,
  // carry instructions
  input wire set_carry_instr_i,
  input wire clear_carry_instr_i,
  // result
  output reg [7:0] flags_o
);
  // -----------------------------
  // flag merge
  // -----------------------------
  // priority bits pass untouched, only result flags move here
  always @* begin
    flags_o = flags_i;
    if (alu_upd_i) begin
      flags_o[`CRSU_BIT_NEG] = alu_result_i[7];
      flags_o[`CRSU_BIT_ZERO] = (alu_result_i == 8'h00);
    end
    if (alu_half_upd_i) begin
      flags_o[`CRSU_BIT_HALF] = alu_half_i;
    end
    // carry from arithmetic, shift, rotate and bit-test; dedicated ops win
    if (alu_carry_upd_i) begin
      flags_o[`CRSU_BIT_CARRY] = alu_carry_i;
    end
    if (set_carry_instr_i) begin
      flags_o[`CRSU_BIT_CARRY] = 1'b1;
    end else if (clear_carry_instr_i) begin
      flags_o[`CRSU_BIT_CARRY] = 1'b0;
    end
  end
endmodule // crsu_flag_calc

// *** logic/crsu_register_unit.v ***
// architectural register set and stack sequencer of an 8-bit core
`timescale 1ns/1ps
`include "crsu_defines.vh"
module crsu_register_unit (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // direct register load/store from the execution logic
  input wire reg_wr_i,
  input wire [2:0] reg_sel_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // program counter control
  input wire pc_load_i,
  input wire [15:0] pc_load_val_i,
  input wire pc_inc_i,
  // alu flag update
  input wire alu_upd_i,
  input wire [7:0] alu_result_i,
  input wire alu_carry_upd_i,
  input wire alu_carry_i,
  input wire alu_half_upd_i,
  input wire alu_half_i,
  input wire set_carry_instr_i,
  input wire clear_carry_instr_i,
  // priority bits control
  input wire prio_wr_i,
  input wire [1:0] prio_wdata_i,
  input wire [1:0] software_priority_regs_i,
  // stack operation request
  input wire stk_req_i,
  input wire [2:0] stk_op_i,
  input wire [2:0] stk_sel_i,
  input wire [15:0] irq_vector_i,
  output wire stk_busy_o,
  output reg stk_done_o,
  // stack memory port
  output reg mem_wr_o,
  output reg mem_rd_o,
  output reg [15:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  input wire [7:0] mem_rdata_i,
  // register views
  output wire [7:0] accumulator_o,
  output wire [7:0] index1_o,
  output wire [7:0] index2_o,
  output wire [15:0] program_counter_o,
  output wire [7:0] condition_flags_o,
  output wire [15:0] stack_pointer_o
);
  // -----------------------------
  // state
  // -----------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_PUSH = 2'd1;
  localparam [1:0] ST_POPA = 2'd2;
  localparam [1:0] ST_POPD = 2'd3;

  reg [1:0] state_ff, nxt_state;
  reg [2:0] op_ff, nxt_op;
  reg [2:0] sel_ff, nxt_sel;
  reg [2:0] cnt_ff, nxt_cnt;
  reg [15:0] vec_ff, nxt_vec;
  reg [7:0] sp_low_ff, nxt_sp_low;
  reg [7:0] flags_ff, nxt_flags;
  reg [7:0] pc_low_ff, nxt_pc_low;
  reg [7:0] pc_high_ff, nxt_pc_high;

  wire [7:0] flags_alu;
  wire [15:0] stack_addr;
  wire [2:0] step;
  reg [2:0] ctx_slot;
  reg [7:0] ctx_byte;
  reg [7:0] push_byte;
  reg acc_wr, idx1_wr, idx2_wr;
  reg [7:0] acc_wd, idx1_wd, idx2_wd;

  // -----------------------------
  // plain data registers
  // -----------------------------
  // accumulator holds alu operands and results
  crsu_byte_reg #(.RST_VAL(8'h00)) u_acc (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(acc_wr),
    .wr_data_i(acc_wd),
    .value_o(accumulator_o)
  );
  crsu_byte_reg #(.RST_VAL(8'h00)) u_idx1 (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(idx1_wr),
    .wr_data_i(idx1_wd),
    .value_o(index1_o)
  );
  // second index is outside the interrupt and call context; only single-byte push and pop reach it
  crsu_byte_reg #(.RST_VAL(8'h00)) u_idx2 (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(idx2_wr),
    .wr_data_i(idx2_wd),
    .value_o(index2_o)
  );

  crsu_flag_calc u_flags (
    .flags_i(flags_ff),
    .alu_upd_i(alu_upd_i),
    .alu_result_i(alu_result_i),
    .alu_carry_upd_i(alu_carry_upd_i),
    .alu_carry_i(alu_carry_i),
    .alu_half_upd_i(alu_half_upd_i),
    .alu_half_i(alu_half_i),
    .set_carry_instr_i(set_carry_instr_i),
    .clear_carry_instr_i(clear_carry_instr_i),
    .flags_o(flags_alu)
  );

  // -----------------------------
  // views and stack address
  // -----------------------------
  // upper stack byte is hard-wired, 256-byte stack
  assign stack_pointer_o = {`CRSU_SP_HIGH, sp_low_ff};
  assign program_counter_o = {pc_high_ff, pc_low_ff};
  assign condition_flags_o = flags_ff;
  assign stack_addr = stack_pointer_o;
  assign stk_busy_o = (state_ff != ST_IDLE);
  assign step = cnt_ff + 3'd1;

  // context slot for push index: 0 pcl,1 pch,2 x,3 a,4 flags; pops run reverse
  always @* begin
    ctx_slot = cnt_ff;
    if (op_ff == `CRSU_STK_INTERRUPT_RETURN_INSTR) begin
      ctx_slot = 3'd4 - cnt_ff;
    end else if (op_ff == `CRSU_STK_RET) begin
      ctx_slot = 3'd1 - cnt_ff;
    end
    case (ctx_slot)
      3'd0: ctx_byte = pc_low_ff;
      3'd1: ctx_byte = pc_high_ff;
      3'd2: ctx_byte = index1_o;
      3'd3: ctx_byte = accumulator_o;
      3'd4: ctx_byte = flags_ff;
      default: ctx_byte = 8'h00;
    endcase
  end

  // single-byte push source; a plain case keeps every register in the sensitivity
  always @* begin
    case (sel_ff)
      `CRSU_SEL_ACC: push_byte = accumulator_o;
      `CRSU_SEL_IDX1: push_byte = index1_o;
      `CRSU_SEL_IDX2: push_byte = index2_o;
      `CRSU_SEL_SPLO: push_byte = sp_low_ff;
      `CRSU_SEL_FLAGS: push_byte = flags_ff;
      `CRSU_SEL_PCLO: push_byte = pc_low_ff;
      `CRSU_SEL_PCHI: push_byte = pc_high_ff;
      default: push_byte = 8'h00;
    endcase
  end

  // -----------------------------
  // read port
  // -----------------------------
  // registers are not memory mapped; this select port is the only access
  always @* begin
    case (reg_sel_i)
      `CRSU_SEL_ACC: reg_rdata_o = accumulator_o;
      `CRSU_SEL_IDX1: reg_rdata_o = index1_o;
      `CRSU_SEL_IDX2: reg_rdata_o = index2_o;
      `CRSU_SEL_SPLO: reg_rdata_o = sp_low_ff;
      `CRSU_SEL_FLAGS: reg_rdata_o = flags_ff;
      `CRSU_SEL_PCLO: reg_rdata_o = pc_low_ff;
      `CRSU_SEL_PCHI: reg_rdata_o = pc_high_ff;
      default: reg_rdata_o = 8'h00;
    endcase
  end

  // -----------------------------
  // next-state logic
  // -----------------------------
  // stack sequencer pushes one byte per cycle and pops one byte per two cycles; direct writes apply only when idle
  always @* begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_sel = sel_ff;
    nxt_cnt = cnt_ff;
    nxt_vec = vec_ff;
    nxt_sp_low = sp_low_ff;
    nxt_flags = flags_alu;
    nxt_pc_low = pc_low_ff;
    nxt_pc_high = pc_high_ff;
    acc_wr = 1'b0;
    idx1_wr = 1'b0;
    idx2_wr = 1'b0;
    acc_wd = reg_wdata_i;
    idx1_wd = reg_wdata_i;
    idx2_wd = reg_wdata_i;
    mem_wr_o = 1'b0;
    mem_rd_o = 1'b0;
    mem_addr_o = stack_addr;
    mem_wdata_o = 8'h00;
    stk_done_o = 1'b0;
    // program counter sequencing
    if (pc_load_i) begin
      {nxt_pc_high, nxt_pc_low} = pc_load_val_i;
    end else if (pc_inc_i) begin
      {nxt_pc_high, nxt_pc_low} = program_counter_o + 16'h0001;
    end
    // software writes to the priority pair (mask set/reset, halt, wait)
    if (prio_wr_i) begin
      nxt_flags[`CRSU_BIT_PRIO_HI] = prio_wdata_i[1];
      nxt_flags[`CRSU_BIT_PRIO_LO] = prio_wdata_i[0];
    end
    case (state_ff)
      ST_IDLE: begin
        if (reg_wr_i) begin
          case (reg_sel_i)
            `CRSU_SEL_ACC: acc_wr = 1'b1;
            `CRSU_SEL_IDX1: idx1_wr = 1'b1;
            `CRSU_SEL_IDX2: idx2_wr = 1'b1;
            `CRSU_SEL_SPLO: nxt_sp_low = reg_wdata_i;
            `CRSU_SEL_FLAGS: nxt_flags = reg_wdata_i;
            `CRSU_SEL_PCLO: nxt_pc_low = reg_wdata_i;
            `CRSU_SEL_PCHI: nxt_pc_high = reg_wdata_i;
            default: nxt_flags = flags_alu;
          endcase
        end
        if (stk_req_i) begin
          nxt_op = stk_op_i;
          nxt_sel = stk_sel_i;
          nxt_vec = irq_vector_i;
          nxt_cnt = 3'd0;
          case (stk_op_i)
            `CRSU_STK_PUSH, `CRSU_STK_IRQ, `CRSU_STK_CALL: nxt_state = ST_PUSH;
            `CRSU_STK_POP, `CRSU_STK_INTERRUPT_RETURN_INSTR, `CRSU_STK_RET: nxt_state = ST_POPA;
            `CRSU_STK_RSP: begin
              nxt_sp_low = `CRSU_SP_LOW_RST;
              stk_done_o = 1'b1;
            end
            default: nxt_state = ST_IDLE;
          endcase
        end
      end
      ST_PUSH: begin
        // write at the free slot, then decrement; 8-bit arithmetic wraps silently
        mem_wr_o = 1'b1;
        mem_wdata_o = (op_ff == `CRSU_STK_PUSH) ? push_byte : ctx_byte;
        nxt_sp_low = sp_low_ff - 8'h01;
        nxt_cnt = step;
        if ((op_ff == `CRSU_STK_PUSH) ||
            (op_ff == `CRSU_STK_CALL && step == `CRSU_CTX_CALL) ||
            (op_ff == `CRSU_STK_IRQ && step == `CRSU_CTX_IRQ)) begin
          nxt_state = ST_IDLE;
          stk_done_o = 1'b1;
          if (op_ff == `CRSU_STK_IRQ) begin
            // context saved: take vector and serviced level
            {nxt_pc_high, nxt_pc_low} = vec_ff;
            nxt_flags[`CRSU_BIT_PRIO_HI] = software_priority_regs_i[1];
            nxt_flags[`CRSU_BIT_PRIO_LO] = software_priority_regs_i[0];
          end
        end
      end
      ST_POPA: begin
        // increment before the read
        nxt_sp_low = sp_low_ff + 8'h01;
        nxt_state = ST_POPD;
      end
      ST_POPD: begin
        mem_rd_o = 1'b1;
        nxt_cnt = step;
        nxt_state = ST_POPA;
        if (op_ff == `CRSU_STK_POP) begin
          case (sel_ff)
            `CRSU_SEL_ACC: acc_wr = 1'b1;
            `CRSU_SEL_IDX1: idx1_wr = 1'b1;
            `CRSU_SEL_IDX2: idx2_wr = 1'b1;
            `CRSU_SEL_FLAGS: nxt_flags = mem_rdata_i;
            default: nxt_flags = flags_alu;
          endcase
          acc_wd = mem_rdata_i;
          idx1_wd = mem_rdata_i;
          idx2_wd = mem_rdata_i;
          nxt_state = ST_IDLE;
          stk_done_o = 1'b1;
        end else begin
          // return paths restore context; second index never touched
          case (ctx_slot)
            3'd0: nxt_pc_low = mem_rdata_i;
            3'd1: nxt_pc_high = mem_rdata_i;
            3'd2: idx1_wr = 1'b1;
            3'd3: acc_wr = 1'b1;
            3'd4: nxt_flags = mem_rdata_i;
            default: nxt_flags = flags_alu;
          endcase
          acc_wd = mem_rdata_i;
          idx1_wd = mem_rdata_i;
          if ((op_ff == `CRSU_STK_INTERRUPT_RETURN_INSTR && step == `CRSU_CTX_IRQ) ||
              (op_ff == `CRSU_STK_RET && step == `CRSU_CTX_CALL)) begin
            nxt_state = ST_IDLE;
            stk_done_o = 1'b1;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // -----------------------------
  // registers
  // -----------------------------
  // undefined flag bits 7,6 come up one; reset loads ones into bits 7,6,5,3
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_IDLE;
      op_ff <= `CRSU_STK_NONE;
      sel_ff <= 3'h0;
      cnt_ff <= 3'h0;
      vec_ff <= 16'h0000;
      sp_low_ff <= `CRSU_SP_LOW_RST;
      flags_ff <= `CRSU_FLAGS_RST;
      pc_low_ff <= 8'h00;
      pc_high_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      sel_ff <= nxt_sel;
      cnt_ff <= nxt_cnt;
      vec_ff <= nxt_vec;
      sp_low_ff <= nxt_sp_low;
      flags_ff <= nxt_flags;
      pc_low_ff <= nxt_pc_low;
      pc_high_ff <= nxt_pc_high;
    end
  end
endmodule // crsu_register_unit

// *** tb/crsu_stack_ram.sv ***
// stack ram model standing on the stack port of the cpu register unit
`timescale 1ns/1ps
module crsu_stack_ram (
  // clock
  input wire clk_sys_i,
  // stack port
  input wire mem_wr_i,
  input wire mem_rd_i,
  input wire [15:0] mem_addr_i,
  input wire [7:0] mem_wdata_i,
  output wire [7:0] mem_rdata_o
);
  // only the low address byte decodes: the stack is 256 bytes deep
  reg [7:0] mem [0:255];
  // async read; outside a read the lines show the inverse so stale data never passes
  assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i[7:0]] : ~mem[mem_addr_i[7:0]];
  // write on the edge that samples the strobe
  always @(posedge clk_sys_i) begin
    if (mem_wr_i) begin
      mem[mem_addr_i[7:0]] <= mem_wdata_i;
    end
  end
endmodule // crsu_stack_ram

// *** tb/crsu_props.sv ***
// concurrent checks on the ports of the cpu register unit
`timescale 1ns/1ps
module crsu_props (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // controls
  input wire reg_wr_i,
  input wire alu_upd_i,
  input wire [7:0] alu_result_i,
  input wire alu_half_upd_i,
  input wire alu_half_i,
  input wire set_carry_instr_i,
  input wire clear_carry_instr_i,
  input wire [1:0] software_priority_regs_i,
  input wire stk_req_i,
  input wire [2:0] stk_op_i,
  input wire [15:0] irq_vector_i,
  // results
  input wire stk_busy_o,
  input wire stk_done_o,
  input wire mem_wr_o,
  input wire mem_rd_o,
  input wire [15:0] mem_addr_o,
  input wire [7:0] index2_o,
  input wire [15:0] program_counter_o,
  input wire [7:0] condition_flags_o,
  input wire [15:0] stack_pointer_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // flag checks only hold when no stack op or direct write competes
  wire idle_ok = !stk_busy_o && !reg_wr_i;
  wire irq_go = stk_req_i && !stk_busy_o && stk_op_i == 3'h3;
  property p_sp_fixed;
    stack_pointer_o[15:8] == 8'h01;
  endproperty
  a_sp_fixed: assert property (p_sp_fixed)
    else $error("stack pointer high byte moved");
  property p_reset_val;
    $rose(reset_n_i) |-> stack_pointer_o == 16'h01ff && (condition_flags_o & 8'he8) == 8'he8;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("wrong values after reset");
  property p_push_dec;
    mem_wr_o |=> stack_pointer_o[7:0] == $past(stack_pointer_o[7:0]) - 8'h01;
  endproperty
  a_push_dec: assert property (p_push_dec)
    else $error("no decrement after a stack write");
  property p_pop_inc;
    mem_rd_o |-> stack_pointer_o[7:0] == $past(stack_pointer_o[7:0]) + 8'h01;
  endproperty
  a_pop_inc: assert property (p_pop_inc)
    else $error("no increment before a stack read");
  property p_addr;
    mem_wr_o || mem_rd_o |-> mem_addr_o == stack_pointer_o;
  endproperty
  a_addr: assert property (p_addr)
    else $error("stack access off the stack pointer");
  property p_push_time;
    stk_req_i && !stk_busy_o && stk_op_i == 3'h1 |=> mem_wr_o && stk_done_o ##1 !stk_busy_o;
  endproperty
  a_push_time: assert property (p_push_time)
    else $error("push timing wrong");
  property p_irq_seq;
    irq_go |=> mem_wr_o [*4] ##1 (mem_wr_o && stk_done_o);
  endproperty
  a_irq_seq: assert property (p_irq_seq)
    else $error("interrupt entry is not five writes");
  property p_irq_end;
    irq_go |-> ##6 program_counter_o == $past(irq_vector_i, 6)
      && {condition_flags_o[5], condition_flags_o[3]} == $past(software_priority_regs_i, 6);
  endproperty
  a_irq_end: assert property (p_irq_end)
    else $error("vector or priority wrong after entry");
  property p_idx2;
    irq_go |=> $stable(index2_o) [*6];
  endproperty
  a_idx2: assert property (p_idx2)
    else $error("second index moved during entry");
  property p_nz;
    alu_upd_i && idle_ok |=> condition_flags_o[2] == $past(alu_result_i[7])
      && condition_flags_o[1] == ($past(alu_result_i) == 8'h00);
  endproperty
  a_nz: assert property (p_nz)
    else $error("negative or zero flag wrong");
  property p_carry;
    (set_carry_instr_i || clear_carry_instr_i) && idle_ok |=>
      condition_flags_o[0] == $past(set_carry_instr_i);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry instruction ignored");
  property p_half;
    alu_half_upd_i && idle_ok |=> condition_flags_o[4] == $past(alu_half_i);
  endproperty
  a_half: assert property (p_half)
    else $error("half carry wrong");
endmodule // crsu_props
bind crsu_register_unit crsu_props u_props (.*);

// *** tb/tb.sv ***
// self-checking bench of the cpu register unit
`timescale 1ns/1ps
module tb;
  reg clk_sys_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg reg_wr, pc_load, pc_inc, alu_upd, c_upd, c_val, h_upd, h_val, set_carry_instr, clear_carry_instr, prio_wr, stk_req;
  reg [2:0] reg_sel, stk_op, stk_sel;
  reg [7:0] wdata, alu_res, cc0;
  reg [15:0] pc_val, vec;
  reg [1:0] prio_val, sw_prio;
  wire busy, done, mwr, mrd;
  wire [15:0] maddr, pc, sp;
  wire [7:0] mwdata, mrdata, rdata, acc, x1, x2, cc;
  integer n_errors = 0;
  integer n_checks = 0;
  integer k;
  integer w;
  crsu_register_unit DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr),
    .reg_sel_i(reg_sel), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .pc_load_i(pc_load),
    .pc_load_val_i(pc_val), .pc_inc_i(pc_inc), .alu_upd_i(alu_upd), .alu_result_i(alu_res),
    .alu_carry_upd_i(c_upd), .alu_carry_i(c_val), .alu_half_upd_i(h_upd), .alu_half_i(h_val),
    .set_carry_instr_i(set_carry_instr), .clear_carry_instr_i(clear_carry_instr), .prio_wr_i(prio_wr),
    .prio_wdata_i(prio_val), .software_priority_regs_i(sw_prio), .stk_req_i(stk_req),
    .stk_op_i(stk_op), .stk_sel_i(stk_sel), .irq_vector_i(vec), .stk_busy_o(busy),
    .stk_done_o(done), .mem_wr_o(mwr), .mem_rd_o(mrd), .mem_addr_o(maddr),
    .mem_wdata_o(mwdata), .mem_rdata_i(mrdata), .accumulator_o(acc), .index1_o(x1),
    .index2_o(x2), .program_counter_o(pc), .condition_flags_o(cc), .stack_pointer_o(sp));
  crsu_stack_ram u_ram (.clk_sys_i(clk_sys_i), .mem_wr_i(mwr), .mem_rd_i(mrd),
    .mem_addr_i(maddr), .mem_wdata_i(mwdata), .mem_rdata_o(mrdata));
  // 100 mhz clock
  always #5 clk_sys_i = ~clk_sys_i;
  //--------------------------------------------------
  // access tasks, all driven at the falling edge
  //--------------------------------------------------
  task chk(input string what, input [15:0] exp, input [15:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wreg(input [2:0] s, input [7:0] d);
    begin
      @(negedge clk_sys_i);
      reg_wr = 1'b1;
      reg_sel = s;
      wdata = d;
      @(negedge clk_sys_i);
      reg_wr = 1'b0;
    end
  endtask
  task rchk(input [2:0] s, input [7:0] e);
    begin
      @(negedge clk_sys_i);
      reg_sel = s;
      #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
    end
  endtask
  // request held one edge only; completion waited for under a bound
  task stk(input [2:0] op, input [2:0] s);
    begin
      @(negedge clk_sys_i);
      stk_req = 1'b1;
      stk_op = op;
      stk_sel = s;
      @(negedge clk_sys_i);
      stk_req = 1'b0;
      for (w = 0; w < 20 && busy === 1'b1; w = w + 1)
        @(negedge clk_sys_i);
      chk("busy", 16'h0000, {15'h0000, busy});
    end
  endtask
  task pulse(input [15:0] v, input [11:0] m);
    begin
      @(negedge clk_sys_i);
      {pc_load, pc_inc, alu_upd, c_upd, c_val, h_upd, h_val, set_carry_instr, clear_carry_instr, prio_wr} = m[9:0];
      pc_val = v;
      alu_res = v[7:0];
      prio_val = v[1:0];
      @(negedge clk_sys_i);
      {pc_load, pc_inc, alu_upd, c_upd, c_val, h_upd, h_val, set_carry_instr, clear_carry_instr, prio_wr} = 10'h000;
    end
  endtask
  task wrap_up;
    begin
      if (n_errors == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // watchdog well beyond the fewer than a hundred cycles the tests need
  initial begin
    #200000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  //--------------------------------------------------
  // test sequence
  //--------------------------------------------------
  initial begin
    {reg_wr, pc_load, pc_inc, alu_upd, c_upd, c_val, h_upd, h_val, set_carry_instr, clear_carry_instr, prio_wr} = 11'h000;
    {stk_req, reg_sel, stk_op, stk_sel, wdata, alu_res, pc_val, prio_val} = 44'h0;
    sw_prio = 2'h1;
    vec = 16'hffe0;
    repeat (3) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    chk("sp", 16'h01ff, sp);
    chk("flags", 16'h00e8, {8'h00, cc & 8'he8});
    for (k = 0; k < 3; k = k + 1)
      wreg(k[2:0], 8'h3c ^ k[7:0]);
    for (k = 0; k < 3; k = k + 1)
      rchk(k[2:0], 8'h3c ^ k[7:0]);
    pulse(16'hab12, 12'h200);
    pulse(16'h0000, 12'h100);
    chk("pc", 16'hab13, pc);
    wreg(3'h3, 8'h00);
    stk(3'h1, 3'h0);
    chk("sp wrap down", 16'h01ff, sp);
    stk(3'h2, 3'h2);
    chk("sp wrap up", 16'h0100, sp);
    chk("popped", 16'h003c, {8'h00, x2});
    // flag results: half, negative, zero, carry
    pulse(16'h0080, 12'h0d8);
    chk("flags a", 16'h000c, {12'h000, cc[4], cc[2:0]});
    pulse(16'h0000, 12'h0f0);
    chk("flags b", 16'h0003, {12'h000, cc[4], cc[2:0]});
    for (k = 1; k < 4; k = k + 1) begin
      pulse(16'h0000, {9'h000, k[0], k[1], 1'b0});
      chk("carry", {15'h0000, k[0]}, {15'h0000, cc[0]});
    end
    stk(3'h1, 3'h4);
    pulse(16'h0000, 12'h002);
    stk(3'h2, 3'h4);
    chk("flags pop", 16'h0001, {15'h0000, cc[0]});
    for (k = 0; k < 4; k = k + 1) begin
      pulse({14'h0000, k[1:0]}, 12'h001);
      chk("prio", {14'h0000, k[1:0]}, {14'h0000, cc[5], cc[3]});
    end
    wreg(3'h3, 8'h40);
    stk(3'h7, 3'h0);
    chk("sp rsp", 16'h01ff, sp);
    pulse(16'h0002, 12'h001);
    cc0 = cc;
    stk(3'h3, 3'h0);
    chk("pcl", 16'h0013, {8'h00, u_ram.mem[8'hff]});
    chk("pch", 16'h00ab, {8'h00, u_ram.mem[8'hfe]});
    chk("idx1", 16'h003d, {8'h00, u_ram.mem[8'hfd]});
    chk("acc", 16'h003c, {8'h00, u_ram.mem[8'hfc]});
    chk("cc", {8'h00, cc0}, {8'h00, u_ram.mem[8'hfb]});
    chk("sp irq", 16'h01fa, sp);
    chk("vector", 16'hffe0, pc);
    chk("prio irq", 16'h0001, {14'h0000, cc[5], cc[3]});
    chk("idx2", 16'h003c, {8'h00, x2});
    wreg(3'h0, 8'h00);
    wreg(3'h1, 8'h00);
    stk(3'h4, 3'h0);
    chk("ret pc", 16'hab13, pc);
    chk("ret ctx", {8'h3c, cc0}, {acc, cc});
    chk("ret idx", 16'hff3d, {sp[7:0], x1});
    stk(3'h5, 3'h0);
    chk("sp call", 16'h01fd, sp);
    chk("call bytes", 16'h13ab, {u_ram.mem[8'hff], u_ram.mem[8'hfe]});
    pulse(16'h0042, 12'h200);
    stk(3'h6, 3'h0);
    chk("ret", 16'hab13, pc);
    chk("sp ret", 16'h01ff, sp);
    wrap_up;
  end
endmodule // tb
